// File: verilog/cpuid_extended_leaf_responder.sv
// Extended identification leaf responder for the execution path
//
// Contract
// - Feature word: bits 0,4,5,8,15,23,24 only
// - Name leaves return ASCII name, little-endian
// - Three leaves carry name words 1-12 in order
// - Unused name bytes return NUL
// - Descriptor leaf TLB_DESCRIPTOR[15:8] is 70h
// - Descriptor leaf TLB_DESCRIPTOR[7:0] is 01h
// - Descriptor leaf L1_CACHE_DESCRIPTOR[7:0] is 80h
// - Highest extended leaf reported as 80000005h
`timescale 1ns/1ps
`default_nettype none
`include "cpuid_ext_consts.svh"

module cpuid_extended_leaf_responder #(
  parameter int              NAME_LEN = 16,
  // Arbitrary neutral name string
  parameter logic [8*48-1:0] NAME     = "Generic x86 Core",
  // Arbitrary stepping value
  parameter logic [3:0]      STEPPING = 4'h0
) (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  // Query from the execution path
  input  wire cpuid_ext_pkg::query_t  i_query,
  // Answer, two cycles after the query
  output logic                        o_valid,
  output logic                        o_hit,
  output cpuid_ext_pkg::result_t      o_result
);
  import cpuid_ext_pkg::*;

  // ----------------------------------------------------------------------
  // Leaf decode
  // ----------------------------------------------------------------------
  wire logic       in_ext_range;
  wire logic [2:0] leaf_sub;
  leaf_kind_t      kind;

  // Only the six extended leaves match; the rest are left to others
  assign in_ext_range = (i_query.leaf >= `CX_LEAF_MAX_QUERY) &&
                        (i_query.leaf <= `CX_LEAF_HIGHEST);
  assign leaf_sub     = i_query.leaf[2:0];

  always_comb begin
    kind = LK_NONE;
    if (in_ext_range) begin
      case (leaf_sub)
        3'h0:    kind = LK_MAX;
        3'h1:    kind = LK_FEAT;
        3'h2,
        3'h3,
        3'h4:    kind = LK_NAME;
        3'h5:    kind = LK_CACHE;
        default: kind = LK_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Constant answers
  // ----------------------------------------------------------------------
  wire logic [31:0] feat_word;
  wire logic [31:0] sig_word;
  wire logic [31:0] tlb_word;
  wire logic [31:0] l1_word;
  result_t          fixed_words;

  assign feat_word = (32'h1 << `CX_FEAT_FPU_BIT)
                   | (32'h1 << `CX_FEAT_TSC_BIT)
                   | (32'h1 << `CX_FEAT_MSR_BIT)
                   | (32'h1 << `CX_FEAT_CX8_BIT)
                   | (32'h1 << `CX_FEAT_CMOV_BIT)
                   | (32'h1 << `CX_FEAT_SIMD_BIT)
                   | (32'h1 << `CX_FEAT_MMEXT_BIT);

  // Signature; upper half reserved and zero
  assign sig_word = ({28'h0, STEPPING}       << `CX_SIG_STEP_POS)
                  | ({28'h0, `CX_SIG_MODEL}  << `CX_SIG_MODEL_POS)
                  | ({28'h0, `CX_SIG_FAMILY} << `CX_SIG_FAMILY_POS)
                  | ({28'h0, `CX_SIG_TYPE}   << `CX_SIG_TYPE_POS);

  // One query gives all cache info
  assign tlb_word = ({24'h0, `CX_TLB_DESC}    << `CX_TLB_DESC_POS)
                  | ({24'h0, `CX_QUERY_COUNT} << `CX_QUERY_COUNT_POS);

  assign l1_word  = {24'h0, `CX_L1_DESC} << `CX_L1_DESC_POS;

  always_comb begin
    fixed_words = '0;
    case (kind)
      LK_MAX: begin
        fixed_words.eax = `CX_LEAF_HIGHEST;
      end
      LK_FEAT: begin
        fixed_words.eax = sig_word;
        fixed_words.extended_feature_flags = feat_word;
      end
      LK_CACHE: begin
        fixed_words.tlb_descriptor = tlb_word;
        fixed_words.l1_cache_descriptor = l1_word;
      end
      default: begin
        fixed_words = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Name store
  // ----------------------------------------------------------------------
  wire logic [31:0] name_row_full;
  wire logic [1:0]  name_row;
  result_t          name_words;

  // Name leaves map to rows 0..2
  assign name_row_full = i_query.leaf - `CX_LEAF_NAME_FIRST;
  assign name_row      = (kind == LK_NAME) ? name_row_full[1:0] : 2'h3;

  // Name string packed in the store
  cpuid_name_rom #(
    .NAME_LEN (NAME_LEN),
    .NAME     (NAME)
  ) u_name_rom (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_rd_en  (i_query.valid),
    .i_row    (name_row),
    .o_words  (name_words)
  );

  // ----------------------------------------------------------------------
  // Stage one: hold the decoded query beside the store read
  // ----------------------------------------------------------------------
  logic       s1_valid;
  leaf_kind_t s1_kind;
  result_t    s1_fixed;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_valid <= 1'b0;
      s1_kind  <= LK_NONE;
      s1_fixed <= '0;
    end else begin
      s1_valid <= i_query.valid;
      if (i_query.valid) begin
        s1_kind  <= kind;
        s1_fixed <= fixed_words;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Stage two: registered answer
  // ----------------------------------------------------------------------
  wire result_t next_result;
  wire logic    next_hit;

  // Name words come straight from the store row
  assign next_result = (s1_kind == LK_NAME) ? name_words : s1_fixed;
  assign next_hit    = (s1_kind != LK_NONE);

  // Answer holds until the next query lands
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_valid  <= 1'b0;
      o_hit    <= 1'b0;
      o_result <= '0;
    end else begin
      o_valid <= s1_valid;
      if (s1_valid) begin
        o_hit    <= next_hit;
        o_result <= next_result;
      end
    end
  end

endmodule
`default_nettype wire

// File: verilog/cpuid_ext_consts.svh
// Constants for the extended identification leaf responder
`ifndef CPUID_EXT_CONSTS_SVH
`define CPUID_EXT_CONSTS_SVH

// ----------------------------------------------------------------------
// Leaf numbers
// ----------------------------------------------------------------------
`define CX_LEAF_MAX_QUERY   32'h8000_0000
`define CX_LEAF_FEATURES    32'h8000_0001
`define CX_LEAF_NAME_FIRST  32'h8000_0002
`define CX_LEAF_NAME_LAST   32'h8000_0004
`define CX_LEAF_CACHE       32'h8000_0005
`define CX_LEAF_HIGHEST     32'h8000_0005

// ----------------------------------------------------------------------
// Extended feature word bit positions
// ----------------------------------------------------------------------
`define CX_FEAT_FPU_BIT     0
`define CX_FEAT_TSC_BIT     4
`define CX_FEAT_MSR_BIT     5
`define CX_FEAT_CX8_BIT     8
`define CX_FEAT_CMOV_BIT    15
`define CX_FEAT_SIMD_BIT    23
`define CX_FEAT_MMEXT_BIT   24

// ----------------------------------------------------------------------
// Signature fields of the feature leaf
// ----------------------------------------------------------------------
`define CX_SIG_STEP_POS     0
`define CX_SIG_MODEL_POS    4
`define CX_SIG_FAMILY_POS   8
`define CX_SIG_TYPE_POS     12
`define CX_SIG_MODEL        4'h4
`define CX_SIG_FAMILY       4'h5
`define CX_SIG_TYPE         4'h0

// ----------------------------------------------------------------------
// TLB and cache descriptor bytes
// ----------------------------------------------------------------------
`define CX_TLB_DESC_POS     8
`define CX_TLB_DESC         8'h70
`define CX_QUERY_COUNT_POS  0
`define CX_QUERY_COUNT      8'h01
`define CX_L1_DESC_POS      0
`define CX_L1_DESC          8'h80

// ----------------------------------------------------------------------
// Name string geometry and reset values
// ----------------------------------------------------------------------
`define CX_NAME_CHARS       48
`define CX_NAME_WORDS       12
`define CX_NAME_PAD         8'h00
`define CX_WORD_RESET       32'h0000_0000

`endif

// File: verilog/cpuid_ext_pkg.sv
// Types shared by the extended identification leaf responder
package cpuid_ext_pkg;

  // One query from the execution path
  typedef struct packed {
    logic        valid;
    logic [31:0] leaf;
  } query_t;

  // The four general result words
  typedef struct packed {
    logic [31:0] eax;
    logic [31:0] tlb_descriptor;
    logic [31:0] l1_cache_descriptor;
    logic [31:0] extended_feature_flags;
  } result_t;

  // Which kind of leaf a query names
  typedef enum logic [2:0] {
    LK_NONE,
    LK_MAX,
    LK_FEAT,
    LK_NAME,
    LK_CACHE
  } leaf_kind_t;

endpackage

// File: verilog/cpuid_name_rom.sv
// Name string store: three rows of four little-endian words
`timescale 1ns/1ps
`default_nettype none
`include "cpuid_ext_consts.svh"

module cpuid_name_rom #(
  parameter int                 NAME_LEN = 16,
  // Arbitrary neutral name, right-aligned, first character highest
  parameter logic [8*48-1:0]    NAME     = "Generic x86 Core"
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  // Read request
  input  wire logic                  i_rd_en,
  input  wire logic [1:0]            i_row,
  // Read data, registered
  output cpuid_ext_pkg::result_t     o_words
);
  import cpuid_ext_pkg::*;

  // ----------------------------------------------------------------------
  // Byte table
  // ----------------------------------------------------------------------
  logic [7:0]  name_byte [`CX_NAME_CHARS];
  logic [31:0] name_word [`CX_NAME_WORDS];

  for (genvar b = 0; b < `CX_NAME_CHARS; b++) begin : g_byte
    assign name_byte[b] = (b < NAME_LEN) ?
                          NAME[8*(NAME_LEN-1-b) +: 8] : `CX_NAME_PAD;
  end
  for (genvar w = 0; w < `CX_NAME_WORDS; w++) begin : g_word
    assign name_word[w] = {name_byte[4*w+3], name_byte[4*w+2],
                           name_byte[4*w+1], name_byte[4*w]};
  end

  // ----------------------------------------------------------------------
  // Row select
  // ----------------------------------------------------------------------
  // Row n gives words 4n+1..4n+4
  wire logic    row_ok = (i_row != 2'h3);
  wire result_t row_words;
  assign row_words.eax = row_ok ? name_word[{i_row, 2'h0}] : `CX_WORD_RESET;
  assign row_words.tlb_descriptor = row_ok ? name_word[{i_row, 2'h1}] : `CX_WORD_RESET;
  assign row_words.l1_cache_descriptor = row_ok ? name_word[{i_row, 2'h2}] : `CX_WORD_RESET;
  assign row_words.extended_feature_flags = row_ok ? name_word[{i_row, 2'h3}] : `CX_WORD_RESET;

  // Registered read keeps the long byte mux off the output path
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_words <= '0;
    end else if (i_rd_en) begin
      o_words <= row_words;
    end
  end

endmodule
`default_nettype wire

// File: bench/exec_path_model.sv
// Execution path model that presents leaf queries
`timescale 1ns/1ps
`default_nettype none
module exec_path_model (
  // Clock and bench request
  input  wire logic            i_clk,
  input  wire logic            i_go,
  input  wire logic [31:0]     i_leaf,
  // Query toward the responder
  output cpuid_ext_pkg::query_t o_query
);
  import cpuid_ext_pkg::*;
  // --------------------------------------------------
  // Query register
  // --------------------------------------------------
  initial o_query = '0;
  // Idle leaf keeps toggling so a stale value never looks valid
  always @(posedge i_clk) begin
    o_query.valid <= i_go;
    o_query.leaf  <= i_go ? i_leaf : ~o_query.leaf;
  end
endmodule
`default_nettype wire

// File: bench/cpuid_ext_properties.sv
// Checker of the extended leaf responder answers
`timescale 1ns/1ps
`default_nettype none
module cpuid_ext_checker #(
  parameter int NAME_LEN = 16
) (
  // Clock, reset and query
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  input  wire cpuid_ext_pkg::query_t  i_query,
  // Answer
  input  wire logic                   o_valid,
  input  wire logic                   o_hit,
  input  wire cpuid_ext_pkg::result_t o_result
);
  import cpuid_ext_pkg::*;
  // --------------------------------------------------
  // Answer checks, two edges after the taking edge
  // --------------------------------------------------
  logic q0, q1, q5, qn;
  assign q0 = i_query.valid && i_query.leaf == 32'h8000_0000;
  assign q1 = i_query.valid && i_query.leaf == 32'h8000_0001;
  assign q5 = i_query.valid && i_query.leaf == 32'h8000_0005;
  assign qn = i_query.valid && i_query.leaf inside {[32'h8000_0002:32'h8000_0004]};
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_MAX_LEAF: assert property (q0 |-> ##2 o_valid && o_hit &&
    o_result == {32'h8000_0005, 96'h0}) else $error("max leaf wrong");
  AST_FEAT_FLAGS: assert property (q1 |-> ##2 o_valid &&
    o_result.extended_feature_flags == 32'h0180_8131) else $error("feature word wrong");
  AST_FEAT_RSVD: assert property (q1 |-> ##2 o_result.eax[31:16] == 16'h0
    && o_result.tlb_descriptor == 32'h0 && o_result.l1_cache_descriptor == 32'h0) else $error("feat rsvd");
  AST_TLB_BYTE: assert property (q5 |-> ##2 o_valid &&
    o_result.tlb_descriptor[15:8] == 8'h70) else $error("tlb byte wrong");
  AST_QUERY_COUNT: assert property (q5 |-> ##2
    o_result.tlb_descriptor[7:0] == 8'h01) else $error("query count wrong");
  AST_L1_BYTE: assert property (q5 |-> ##2
    o_result.l1_cache_descriptor[7:0] == 8'h80) else $error("l1 byte wrong");
  AST_CACHE_RSVD: assert property (q5 |-> ##2 o_result.eax == 32'h0 &&
    o_result.extended_feature_flags == 32'h0 && o_result.tlb_descriptor[31:16] == 16'h0 &&
    o_result.l1_cache_descriptor[31:8] == 24'h0) else $error("cache rsvd not zero");
  // Last name row holds no characters for short names
  AST_NAME_PAD: assert property (qn && i_query.leaf[2] && NAME_LEN <= 32
    |-> ##2 o_valid && o_result == '0) else $error("name pad wrong");
  AST_NAME_HIT: assert property (qn |-> ##2 o_valid && o_hit)
    else $error("name leaf missed");
endmodule
bind cpuid_extended_leaf_responder cpuid_ext_checker #(.NAME_LEN(NAME_LEN))
  chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_query(i_query),
       .o_valid(o_valid), .o_hit(o_hit), .o_result(o_result));
`default_nettype wire

// File: bench/tb_top.sv
// Testbench of the extended leaf responder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cpuid_ext_pkg::*;
  localparam logic [31:0] B = 32'h8000_0000;
  logic         i_clk, i_rst_n, go, o_valid, o_hit;
  logic [31:0]  leaf;
  query_t       q;
  result_t      o_result;
  int           n_fail, total_checks;
  logic [128:0] expq[$];
  logic [31:0]  lf_t[8];
  logic [128:0] ex_t[8];
  // --------------------------------------------------
  // Design and far side
  // --------------------------------------------------
  exec_path_model pm (.i_clk(i_clk), .i_go(go), .i_leaf(leaf), .o_query(q));
  cpuid_extended_leaf_responder #(.STEPPING(4'h3)) uut (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_query(q), .o_valid(o_valid), .o_hit(o_hit),
    .o_result(o_result));
  task automatic check(input logic [128:0] seen, input logic [128:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic issue(input int i);
    go   <= 1'h1;
    leaf <= lf_t[i];
    expq.push_back(ex_t[i]);
    @(posedge i_clk);
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Each answer pops the oldest expectation
  always @(posedge i_clk) begin
    if (i_rst_n && o_valid === 1'h1) begin
      if (expq.size() == 0)
        check(129'h1, 129'h0);
      else
        check({o_hit, o_result}, expq.pop_front());
    end
  end
  initial begin
    i_clk = 1'h0;
    forever #12.5 i_clk = ~i_clk;
  end
  // Watchdog well beyond the expected run
  initial begin
    #(25 * 2000);
    n_fail++;
    give_verdict;
  end
  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial begin
    i_rst_n = 1'h0;
    go = 1'h0;
    leaf = 32'h0;
    n_fail = 0;
    total_checks = 0;
    lf_t = '{B, B + 1, B + 2, B + 3, B + 4, B + 5, 32'h7fff_ffff, B + 6};
    ex_t = '{{1'h1, 32'h8000_0005, 96'h0},
             {1'h1, 32'h0000_0543, 64'h0, 32'h0180_8131},
             {1'h1, 128'h656e6547_20636972_20363878_65726f43},
             {1'h1, 128'h0}, {1'h1, 128'h0},
             {1'h1, 32'h0, 32'h0000_7001, 32'h0000_0080, 32'h0},
             129'h0, 129'h0};
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'h1;
    // Leaves one at a time
    foreach (lf_t[i]) begin
      issue(i);
      go <= 1'h0;
      repeat (6) @(posedge i_clk);
    end
    // Back to back with valid held high
    foreach (lf_t[i]) issue(i);
    go <= 1'h0;
    repeat (8) @(posedge i_clk);
    check(129'(expq.size()), 129'h0);
    // Reset lands while two answers are in flight
    issue(1);
    issue(5);
    go <= 1'h0;
    @(posedge i_clk);
    i_rst_n <= 1'h0;
    expq.delete();
    repeat (6) @(posedge i_clk);
    check({o_valid | o_hit, o_result}, 129'h0);
    i_rst_n <= 1'h1;
    // Query at the first edge after release
    issue(5);
    go <= 1'h0;
    repeat (8) @(posedge i_clk);
    check(129'(expq.size()), 129'h0);
    give_verdict;
  end
endmodule
`default_nettype wire
